/* dv/multichannel_dac_serial_control_bench.sv */
// Bench: AHB-Lite host end drives the link into the device end.
// Assumes short acquisition counts; hready is the host's hreadyout.
`timescale 1ns/100ps
module multichannel_dac_serial_control_bench import sdac_pkg::*;;
  logic              ref_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              hsel = 1'b1;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = 32'h0;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              interface_select = 1'b1;
  logic [CODE_W-1:0] vin_code = 14'h0;
  logic [5:0]        rd_ch = 6'h0;
  logic [CODE_W-1:0] rd_code;
  logic              vin_routed;
  logic              soft_reset;
  logic              sr_seen = 1'b0;
  logic [31:0]       r;
  int                n;
  int                compares = 0;
  int                fail_count = 0;

  // ==========================================================
  // Clock, ends of the link and checker
  always #5 ref_clk = ~ref_clk;
  sdac_if lnk_if ();
  sdac_dev #(.ACQ_CYC_P(40), .BCAST_CYC_P(100)) sdac_dev_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk_if),
    .interface_select(interface_select), .vin_code(vin_code),
    .rd_ch(rd_ch), .rd_code(rd_code), .vin_routed(vin_routed),
    .soft_reset(soft_reset));
  sdac_host sdac_host_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .lnk(lnk_if));
  sdac_checker sdac_checker_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .sync_n(lnk_if.sync_n),
    .sclk(lnk_if.sclk), .din(lnk_if.din), .dout(lnk_if.dout),
    .dout_oe(lnk_if.dout_oe), .busy_n(lnk_if.busy_n),
    .track(lnk_if.track));

  // One-cycle pulse is latched so the test can poll for it
  always @(posedge ref_clk) begin
    if (soft_reset === 1'b1) sr_seen <= 1'b1;
  end

  // ==========================================================
  // Reporting
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic give_up(input string m);
    fail_count++;
    $display("CHECK FAILED t=%0t %s", $time, m);
    wrap_up();
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string m);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  // ==========================================================
  // Bus and link access
  task automatic ready_edge();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) give_up("hready stuck low");
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    ready_edge();
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask
  // Idle means no frame pending and no acquisition running
  task automatic wait_idle();
    logic [31:0] s;
    int k;
    k = 0;
    do begin
      rd(REG_STAT, s);
      k++;
    end while (s[1:0] !== 2'b10 && k < 3000);
    if (k >= 3000) give_up("link never idle");
  endtask
  task automatic send(input sdac_mode_t md, input logic bc,
                      input logic os, input logic [4:0] ch,
                      input logic [13:0] code);
    logic [9:0] h;
    h = {md, bc, os, 1'b0, ch}; // Test bit always low
    if (md == MD_LOAD) wr(REG_CMD, {8'h0, code, h});
    else wr(REG_CMD, {22'h0, h});
    wait_idle();
  endtask
  // Code register view lags rd_ch by one cycle
  task automatic chk_ch(input logic [5:0] ch, input logic [13:0] e,
                        input string m);
    rd_ch <= ch;
    repeat (2) @(posedge ref_clk);
    check({18'h0, rd_code}, {18'h0, e}, m);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(REG_TRK, r);
    check({31'h0, r[0]}, 32'h1, "track level at reset");
    check({31'h0, hresp}, 32'h0, "okay response");
    rd(32'h10, r);
    check(r, 32'h0, "unmapped read");
    chk_ch(6'd0, 14'h0, "code at reset");
    $display("test reset done");
    send(MD_LOAD, 1'b0, 1'b0, 5'd5, 14'h2abc);
    send(MD_LOAD, 1'b0, 1'b1, 5'd5, 14'h1111);
    chk_ch(6'd5, 14'h2abc, "load ch5");
    chk_ch(OFFS_CH, 14'h1111, "offset load");
    chk_ch(6'd4, 14'h0, "neighbour kept");
    send(MD_RB, 1'b0, 1'b0, 5'd5, 14'h0);
    rd(REG_RX, r);
    check({18'h0, r[13:0]}, 32'h2abc, "readback ch5");
    send(MD_RB, 1'b0, 1'b1, 5'd0, 14'h0);
    rd(REG_RX, r);
    check({18'h0, r[13:0]}, 32'h1111, "readback offset");
    $display("test load_readback done");
    vin_code <= 14'h0777;
    send(MD_HOLD, 1'b0, 1'b0, 5'd7, 14'h0);
    chk_ch(6'd7, 14'h0777, "hold ch7");
    vin_code <= 14'h0333;
    send(MD_ACQRB, 1'b0, 1'b0, 5'd9, 14'h0);
    rd(REG_RX, r);
    check({18'h0, r[13:0]}, 32'h0333, "acquire readback");
    $display("test acquire done");
    wr(REG_TRK, 32'h0);
    vin_code <= 14'h0aaa;
    send(MD_HOLD, 1'b0, 1'b0, 5'd10, 14'h0);
    check({31'h0, vin_routed}, 32'h1, "input routed");
    chk_ch(6'd10, 14'h0, "deferred");
    wr(REG_TRK, 32'h1);
    n = 0;
    while (vin_routed !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) give_up("acquisition after track rise stuck");
    wait_idle();
    chk_ch(6'd10, 14'h0aaa, "acquired on track rise");
    $display("test track done");
    send(MD_LOAD, 1'b1, 1'b0, 5'd0, 14'h2000);
    for (int c = 0; c < 32; c++) chk_ch(6'(c), 14'h3fff, "ones");
    chk_ch(OFFS_CH, 14'h1111, "offset kept");
    send(MD_LOAD, 1'b1, 1'b0, 5'd0, 14'h0);
    for (int c = 0; c < 32; c++) chk_ch(6'(c), 14'h0, "zeros");
    vin_code <= 14'h0155;
    send(MD_HOLD, 1'b1, 1'b0, 5'd0, 14'h0);
    for (int c = 0; c < 32; c++) chk_ch(6'(c), 14'h0155, "all");
    $display("test broadcast done");
    interface_select <= 1'b0;
    send(MD_LOAD, 1'b0, 1'b0, 5'd3, 14'h1234);
    chk_ch(6'd3, 14'h0155, "link disabled");
    interface_select <= 1'b1;
    repeat (5) @(posedge ref_clk);
    wr(REG_TRK, 32'h3);
    n = 0;
    while (sr_seen !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, sr_seen}, 32'h1, "reset pulse");
    repeat (10) @(posedge ref_clk);
    chk_ch(6'd7, 14'h0, "cleared ch7");
    chk_ch(OFFS_CH, 14'h0, "cleared offset");
    $display("test soft_reset done");
    wrap_up();
  end
endmodule // multichannel_dac_serial_control_bench

/* dv/sdac_checker.sv */
// Assertions on the serial DAC link wires between host and device.
// Assumes the bench hands in the interface signals by name.
`timescale 1ns/100ps
module sdac_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link wires
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic busy_n,
  input wire logic track
);
  // Longest bench acquisition plus margin for pin synchronisers
  localparam int BUSY_MAX = 200;

  // ==========================================================
  // Link properties, all on ref_clk
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_sclk_idle_low: assert property (sync_n |-> !sclk)
    else $error("sclk high outside a frame");
  a_din_quiet_rb: assert property (dout_oe |-> !din)
    else $error("din moves during readback");
  a_oe_in_frame: assert property (dout_oe |-> !sync_n)
    else $error("dout driven outside a frame");
  a_oe_on_rise: assert property ($rose(dout_oe) |-> sclk)
    else $error("dout enabled away from a rising clock");
  // Output may only move while sclk is high, before the sampling fall
  a_dout_on_rise: assert property
    (dout_oe && $past(dout_oe) && $changed(dout) |-> sclk)
    else $error("dout changed while sclk low");
  a_frame_when_free: assert property ($fell(sync_n) |-> busy_n)
    else $error("frame started during acquisition");
  a_busy_min_len: assert property ($fell(busy_n) |-> !busy_n[*8])
    else $error("acquisition too short");
  a_busy_bounded: assert property
    ($fell(busy_n) |-> ##[1:BUSY_MAX] busy_n)
    else $error("acquisition never ends");
  a_gap_after: assert property ($rose(sync_n) |-> sync_n[*8])
    else $error("frames too close");

  // ==========================================================
  // Scenario coverage
  c_readback: cover property ($rose(dout_oe));
  c_acquire: cover property ($fell(busy_n));
  c_track_pulse: cover property ($fell(track) ##[1:20] track);
endmodule // sdac_checker

/* rtl/sdac_dev.sv */
// Device end of the serial DAC link: frame decode, 33 code registers,
// acquisition timing, readback and the track / reset pin.
// Assumes vin_code is the acquired input on ref_clk; link pins are async.
//
// Summary of operation
// - Track high: acquire as soon as addressed.
// - Track low: route input, acquire on track rise.
// - Busy low during acquisition; then DAC drives.
// - First two bits select one of four modes.
// - Acquire-and-hold word is ten bits, MSB first.
// - DAC load word: ten address bits, 14 code.
// - Host waits 400 ns between DAC loads.
// - Acquire then read back code next frame.
// - Readback mode: no acquisition, code out next frame.
// - Host waits 400 ns before readback frame.
// - Readback bits change on rising serial clock.
// - Broadcast load fills all 32 registers.
// - Broadcast hold acquires all 32 channels together.
// - Offset select overrides the channel address.
// - Host always sends test bit as zero.
// - Five-bit address picks one of 32.
// - Code field written only in DAC load.
// - Frame start clears count; extra selects ignored.
// - After full count, clocks ignored until reframe.
// - Output driven from first rise to 14th fall.
// - Input latched on falls; ignored in readback.
// - Interface select high enables the serial link.
// - 90-200 ns low track pulse resets device.
`timescale 1ns/100ps
module sdac_dev import sdac_pkg::*; #(
  parameter int ACQ_CYC_P   = ACQ_CYC,
  parameter int BCAST_CYC_P = BCAST_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Link
  sdac_if.dev                    lnk,
  // User side
  input  wire logic              interface_select,
  input  wire logic [CODE_W-1:0] vin_code,
  input  wire logic [5:0]        rd_ch,
  output logic      [CODE_W-1:0] rd_code,
  output logic                   vin_routed,
  output logic                   soft_reset
);
  typedef enum logic [3:0] {
    FR_IDLE = 4'h1,
    FR_WR   = 4'h2,
    FR_RD   = 4'h4,
    FR_DONE = 4'h8
  } sdac_fr_t;

  // True when entry i is a target of a single or broadcast write
  function automatic logic hit_f(input int i, input logic all,
                                 input logic [5:0] ch);
    hit_f = all ? (i < N_CH) : (ch == 6'(i));
  endfunction

  logic [4:0]        s_q, s_rise, s_fall;
  sdac_fr_t          fr_q;
  logic [4:0]        cnt_q;
  logic [23:0]       sr_q;
  sdac_mode_t        mode_q;
  logic [CODE_W-1:0] rb_q, code_q, rd_code_q;
  logic [HDR_W-1:0]  hdr_q;
  logic              dout_q, oe_q, exec_q, rd_done_q;
  logic              acq_q, all_q, pend_q, routed_q, rd_pend_q;
  logic [12:0]       acq_cnt_q;
  logic [5:0]        ch_q, rb_ch_q;
  logic [7:0]        lo_q;
  logic [CODE_W-1:0] dac_q [N_CH+1];

  // ==========================================================
  // Pin synchronisers
  sdac_sync #(.W(5), .INIT(5'h09)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({interface_select, lnk.track, lnk.din, lnk.sclk,
               lnk.sync_n}),
    .q       (s_q),
    .rise    (s_rise),
    .fall    (s_fall)
  );

  wire       ser_en  = s_q[4];
  wire       trk_s   = s_q[3];
  wire       din_s   = s_q[2];
  wire       sclk_r  = s_rise[1];
  wire       sclk_f  = s_fall[1];
  wire       sync_f  = s_fall[0];
  wire       trk_r   = s_rise[3];

  // ==========================================================
  // Track pin: a short low pulse resets, a long one is the track level
  wire       trk_long = lo_q > 8'(RST_MAX_CYC);
  wire       soft_rst = trk_r && lo_q >= 8'(RST_MIN_CYC)
                        && lo_q <= 8'(RST_MAX_CYC);

  // Saturating low-time counter, kept through soft reset to see the rise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      lo_q <= 8'h00;
    else if (trk_s)
      lo_q <= 8'h00;
    else if (lo_q != 8'hff)
      lo_q <= lo_q + 8'h01;
  end

  // ==========================================================
  // Frame decode
  wire [4:0]        need   = (mode_q == MD_LOAD) ? LOAD_BITS
                                               : HOLD_BITS;
  wire [HDR_W-1:0]  hdr_w  = (mode_q == MD_LOAD) ? sr_q[23:14]
                                               : sr_q[HDR_W-1:0];
  wire              frm_ok = (fr_q == FR_IDLE || fr_q == FR_DONE);

  // Frame sequencer; selects inside a frame are not seen at all
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fr_q <= FR_IDLE;  cnt_q <= 5'h00;   sr_q <= 24'h000000;
      mode_q <= MD_HOLD; rb_q <= DAC_RST; dout_q <= 1'b0;
      oe_q <= 1'b0;     exec_q <= 1'b0;   rd_done_q <= 1'b0;
      hdr_q <= 10'h000; code_q <= DAC_RST;
    end else if (soft_rst) begin
      fr_q <= FR_IDLE;  cnt_q <= 5'h00;   oe_q <= 1'b0;
      exec_q <= 1'b0;   rd_done_q <= 1'b0;
      mode_q <= MD_HOLD;
    end else begin
      exec_q    <= 1'b0;
      rd_done_q <= 1'b0;
      case (fr_q)
        FR_IDLE, FR_DONE: begin
          if (sync_f && ser_en) begin
            fr_q  <= rd_pend_q ? FR_RD : FR_WR;
            cnt_q <= 5'h00;
            rb_q  <= dac_q[rb_ch_q];
          end
        end
        FR_WR: begin
          if (cnt_q == need) begin
            exec_q <= 1'b1;
            hdr_q  <= hdr_w;
            code_q <= sr_q[CODE_W-1:0];
            fr_q   <= FR_DONE;
          end else if (sclk_f) begin
            sr_q  <= {sr_q[22:0], din_s};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h01)
              mode_q <= sdac_mode_t'({sr_q[0], din_s});
          end
        end
        FR_RD: begin
          if (sclk_r) begin
            oe_q   <= 1'b1;
            dout_q <= rb_q[RB_LAST - cnt_q[3:0]];
          end
          if (sclk_f) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == RB_BITS - 5'h01) begin
              oe_q      <= 1'b0;
              fr_q      <= FR_DONE;
              rd_done_q <= 1'b1;
            end
          end
        end
        default: fr_q <= FR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Command fields
  wire [1:0] md_bits = hdr_q[MODE_HI:MODE_LO];
  wire       e_all   = hdr_q[BCAST_BIT];
  wire [5:0] e_ch    = hdr_q[OFFS_BIT] ? OFFS_CH
                       : {1'b0, hdr_q[ADDR_HI:0]};
  wire       e_acq   = exec_q && (md_bits == MD_HOLD
                       || md_bits == MD_ACQRB);
  wire       e_ld    = exec_q && md_bits == MD_LOAD;
  wire       e_rb    = exec_q && md_bits[1];
  wire [CODE_W-1:0] ld_val = e_all ? {CODE_W{code_q[CODE_W-1]}}
                                   : code_q;
  // Start now if track is high, or when a long low ends
  wire       go_now  = (e_acq && trk_s)
                       || (trk_r && trk_long && pend_q);
  wire       go_all  = e_acq ? e_all : all_q;
  wire       acq_end = acq_q && acq_cnt_q == 13'h0000;

  // ==========================================================
  // Acquisition and readback bookkeeping
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acq_q <= 1'b0;  acq_cnt_q <= 13'h0000; ch_q <= 6'h00;
      all_q <= 1'b0;  pend_q <= 1'b0;        routed_q <= 1'b0;
      rd_pend_q <= 1'b0; rb_ch_q <= 6'h00;
    end else if (soft_rst) begin
      acq_q <= 1'b0;  pend_q <= 1'b0;  routed_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (go_now) begin
        acq_q     <= 1'b1;
        acq_cnt_q <= go_all ? 13'(BCAST_CYC_P - 1) : 13'(ACQ_CYC_P - 1);
        pend_q    <= 1'b0;
        routed_q  <= 1'b1;
        all_q     <= go_all;
        if (e_acq)
          ch_q <= e_ch;
      end else if (e_acq) begin
        pend_q   <= 1'b1;
        routed_q <= 1'b1;
        ch_q     <= e_ch;
        all_q    <= e_all;
      end else if (acq_end) begin
        acq_q    <= 1'b0;
        routed_q <= 1'b0;
      end else if (acq_q) begin
        acq_cnt_q <= acq_cnt_q - 13'h0001;
      end
      if (e_rb) begin
        rd_pend_q <= 1'b1;
        rb_ch_q   <= e_ch;
      end else if (rd_done_q) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Code registers; a host load in the same cycle beats an acquisition
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i <= N_CH; i++)
        dac_q[i] <= DAC_RST;
    end else begin
      for (int i = 0; i <= N_CH; i++) begin
        if (soft_rst)
          dac_q[i] <= DAC_RST;
        else if (e_ld && hit_f(i, e_all, e_ch))
          dac_q[i] <= ld_val;
        else if (acq_end && hit_f(i, all_q, ch_q))
          dac_q[i] <= vin_code;
      end
    end
  end

  // User read port; channels past the offset channel read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      rd_code_q <= DAC_RST;
    else
      rd_code_q <= (rd_ch <= OFFS_CH) ? dac_q[rd_ch] : DAC_RST;
  end

  // ==========================================================
  // Outputs
  assign lnk.dout    = dout_q;
  assign lnk.dout_oe = oe_q;
  assign lnk.busy_n  = ~acq_q;
  assign rd_code     = rd_code_q;
  assign vin_routed  = routed_q;
  assign soft_reset  = soft_rst;
endmodule // sdac_dev

/* rtl/sdac_host.sv */
// Host end of the serial DAC link: AHB-Lite register slave that sends
// command frames, fetches readback and pulses the track pin.
// Assumes one AHB master on ref_clk; dout and busy_n are async pins.
`timescale 1ns/100ps
module sdac_host import sdac_pkg::*; #(
  parameter int HALF = 10
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Link
  sdac_if.host             lnk
);
  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_LOW   = 6'h02,
    H_HIGH  = 6'h04,
    H_END   = 6'h08,
    H_GAP   = 6'h10,
    H_PULSE = 6'h20
  } sdac_hst_t;

  logic [1:0]  s_q;
  sdac_hst_t   st_q;
  logic [7:0]  ph_q;
  logic [4:0]  left_q;
  logic [23:0] cmd_q, sr_q;
  logic [CODE_W-1:0] rx_q;
  logic        go_q, rp_q, rbp_q, rd_q, rxv_q, trk_q;
  logic        sync_q, sclk_q, din_q, wen_q;
  logic [31:0] wa_q, rdat_q;

  // ==========================================================
  // Pin synchronisers
  sdac_sync #(.W(2), .INIT(2'h3)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({lnk.busy_n, lnk.dout_line}),
    .q       (s_q),
    .rise    (),
    .fall    ()
  );
  wire busy_ok = s_q[1];
  wire dout_s  = s_q[0];

  // ==========================================================
  // AHB-Lite slave, zero wait states
  wire ap     = hsel && htrans[1] && hready;
  wire idle   = st_q == H_IDLE && !go_q && !rbp_q;
  wire wr_cmd = wen_q && wa_q == REG_CMD;
  wire wr_trk = wen_q && wa_q == REG_TRK;
  wire [31:0] rd_val =
      (haddr == REG_CMD)  ? {8'h00, cmd_q} :
      (haddr == REG_STAT) ? {29'h0, rxv_q, busy_ok, !idle} :
      (haddr == REG_RX)   ? {18'h0, rx_q} :
      (haddr == REG_TRK)  ? {31'h0, trk_q} : 32'h0;

  // Address phase is latched; read data is ready for the data phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wen_q <= 1'b0; wa_q <= 32'h0; rdat_q <= 32'h0; trk_q <= TRK_RST;
    end else begin
      wen_q <= ap && hwrite;
      if (ap)
        wa_q <= haddr;
      if (ap && !hwrite)
        rdat_q <= rd_val;
      if (wr_trk)
        trk_q <= hwdata[0];
    end
  end

  // ==========================================================
  // Frame engine; waits for busy high so acquisitions finish first
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= H_IDLE; ph_q <= 8'h00; left_q <= 5'h00; cmd_q <= 24'h0;
      sr_q <= 24'h0;  rx_q <= 14'h0; go_q <= 1'b0;    rp_q <= 1'b0;
      rbp_q <= 1'b0;  rd_q <= 1'b0;  rxv_q <= 1'b0;
      sync_q <= 1'b1; sclk_q <= 1'b0; din_q <= 1'b0;
    end else begin
      if (wr_cmd && idle) begin
        cmd_q <= hwdata[23:0];
        cmd_q[TEST_BIT] <= 1'b0;
        go_q  <= 1'b1;
      end
      if (ph_q != 8'h00)
        ph_q <= ph_q - 8'h01;
      case (st_q)
        H_IDLE: begin
          if (rp_q) begin
            rp_q <= 1'b0;
            ph_q <= 8'(PULSE_CYC - 1);
            st_q <= H_PULSE;
          end else if (busy_ok && (rbp_q || go_q)) begin
            sync_q <= 1'b0;
            st_q   <= H_LOW;
            ph_q   <= 8'(HALF - 1);
            rd_q   <= rbp_q;
            if (rbp_q) begin
              rbp_q  <= 1'b0;
              left_q <= RB_BITS;
            end else begin
              go_q   <= 1'b0;
              rxv_q  <= 1'b0;
              rbp_q  <= cmd_q[MODE_HI];
              if (cmd_q[MODE_HI:MODE_LO] == MD_LOAD) begin
                left_q <= LOAD_BITS;
                // Header word leads, code bits follow on the wire
                sr_q   <= {cmd_q[HDR_W-1:0], cmd_q[23:HDR_W]};
              end else begin
                left_q <= HOLD_BITS;
                sr_q   <= {cmd_q[HDR_W-1:0], 14'h0};
              end
            end
          end
        end
        H_LOW: begin
          if (ph_q == 8'h00) begin
            if (left_q == 5'h00) begin
              st_q <= H_END;
            end else begin
              sclk_q <= 1'b1;
              din_q  <= rd_q ? 1'b0 : sr_q[23];
              sr_q   <= {sr_q[22:0], 1'b0};
              ph_q   <= 8'(HALF - 1);
              st_q   <= H_HIGH;
            end
          end
        end
        H_HIGH: begin
          if (ph_q == 8'h00) begin
            sclk_q <= 1'b0;
            left_q <= left_q - 5'h01;
            ph_q   <= 8'(HALF - 1);
            st_q   <= H_LOW;
            if (rd_q)
              rx_q <= {rx_q[CODE_W-2:0], dout_s};
          end
        end
        H_END: begin
          sync_q <= 1'b1;
          rxv_q  <= rxv_q | rd_q;
          ph_q   <= 8'(GAP_CYC - 1);
          st_q   <= H_GAP;
        end
        H_GAP, H_PULSE: begin
          if (ph_q == 8'h00)
            st_q <= (st_q == H_PULSE) ? H_GAP : H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
      // A new pulse request beats the clear of the one being taken
      if (wr_trk && hwdata[1])
        rp_q <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdat_q;
  assign lnk.sync_n = sync_q;
  assign lnk.sclk   = sclk_q;
  assign lnk.din    = din_q;
  assign lnk.track  = trk_q && st_q != H_PULSE;
endmodule // sdac_host

/* rtl/sdac_if.sv */
// Link between the serial DAC device and its host controller.
// Assumes the bench joins the two ends; dout is resolved here.
`timescale 1ns/100ps
interface sdac_if;
  logic sync_n;    // Frame select, low during a frame
  logic sclk;      // Serial clock made by the host
  logic din;       // Host to device data
  logic dout;      // Device data value
  logic dout_oe;   // Device drives dout while high
  logic dout_line; // Wire level, pulled high when undriven
  logic busy_n;    // Low while the device acquires
  logic track;     // Track level, short low pulse resets

  // Undriven line reads as a pulled-up level
  assign dout_line = dout_oe ? dout : 1'b1;

  modport dev (input sync_n, sclk, din, track,
               output dout, dout_oe, busy_n);
  modport host (output sync_n, sclk, din, track,
                input dout_line, busy_n);
endinterface

/* rtl/sdac_pkg.sv */
// Shared constants for the serial DAC control link: word layout, modes,
// timing counts and the host's register map.
// Assumes a 100 MHz ref_clk on both ends of the link.
package sdac_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_NS         = 10;
  localparam int T_ACQ_NS       = 16000; // One channel acquisition
  localparam int T_BCAST_NS     = 45000; // All channels together
  localparam int T_RST_MIN_NS   = 90;    // Shortest reset pulse
  localparam int T_RST_MAX_NS   = 200;   // Longest reset pulse
  localparam int T_GAP_NS       = 400;   // Gap after each frame
  localparam int T_PULSE_NS     = 150;   // Reset pulse the host makes
  localparam int ACQ_CYC        = T_ACQ_NS / CLK_NS;
  localparam int BCAST_CYC      = T_BCAST_NS / CLK_NS;
  localparam int RST_MIN_CYC    = (T_RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_MAX_CYC    = T_RST_MAX_NS / CLK_NS;
  localparam int GAP_CYC        = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC      = T_PULSE_NS / CLK_NS;

  // ==========================================================
  // Serial word layout
  localparam int MODE_HI        = 9;
  localparam int MODE_LO        = 8;
  localparam int BCAST_BIT      = 7;
  localparam int OFFS_BIT       = 6;
  localparam int TEST_BIT       = 5;
  localparam int ADDR_HI        = 4;
  localparam int HDR_W          = 10;
  localparam int CODE_W         = 14;
  localparam logic [4:0] HOLD_BITS = 5'h0a;
  localparam logic [4:0] LOAD_BITS = 5'h18;
  localparam logic [4:0] RB_BITS   = 5'h0e;
  localparam logic [3:0] RB_LAST   = 4'hd;
  localparam int N_CH           = 32;
  localparam logic [5:0] OFFS_CH   = 6'h20;
  localparam logic [CODE_W-1:0] DAC_RST = 14'h0000;

  typedef enum logic [1:0] {
    MD_HOLD  = 2'h0,
    MD_LOAD  = 2'h1,
    MD_ACQRB = 2'h2,
    MD_RB    = 2'h3
  } sdac_mode_t;

  // ==========================================================
  // Host register map (byte addresses)
  localparam logic [31:0] REG_CMD  = 32'h0000_0000;
  localparam logic [31:0] REG_STAT = 32'h0000_0004;
  localparam logic [31:0] REG_RX   = 32'h0000_0008;
  localparam logic [31:0] REG_TRK  = 32'h0000_000c;
  localparam logic        TRK_RST  = 1'b1;

endpackage

/* rtl/sdac_sync.sv */
// Two-flop synchroniser with edge detection for pins from another domain.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/100ps
module sdac_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // Pins and results
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  // ==========================================================
  // First stage feeds only the second; edges come from later stages
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign q    = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule // sdac_sync
